// File: rtl/srw_supervisor.sv
// reset supervisor with manual reset, watchdog and write gating
`timescale 1ns/1ps
module srw_supervisor
    import srw_pkg::*;
#(
    parameter bit HAS_KICK_PIN = 1'b1,
    parameter int WDG_CYC = WDG_CYCLES,
    parameter int RST_CYC = RST_CYCLES,
    parameter int DEB_CYC = DEB_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // reset sources
    input wire logic supply_low_in,
    input wire logic manual_reset_in_n,
    // watchdog kick sources
    input wire logic watchdog_kick_in,
    input wire logic sda_in,
    // active-low open-drain reset pin
    input wire logic rst_n_pin_in,
    output logic rst_n_pin_out,
    output logic rst_n_pin_oe_out,
    // active-high reset output
    output logic rst_hi_out,
    // memory write gating
    input wire logic write_protect_in,
    input wire logic mem_wr_load_in,
    input wire logic [ADDR_W-1:0] mem_wr_addr_in,
    input wire logic mem_wr_req_in,
    output logic mem_wr_en_out,
    output logic [ADDR_W-1:0] mem_wr_addr_out,
    output logic mem_wr_blocked_out
);
    localparam int WDG_W = $clog2(WDG_CYC + 1);
    localparam int RST_W = $clog2(RST_CYC + 1);
    localparam logic [WDG_W-1:0] WDG_LAST = WDG_W'(WDG_CYC - 1);
    localparam logic [RST_W-1:0] RST_LAST = RST_W'(RST_CYC - 1);
    localparam int GUARD_W = $clog2(PIN_GUARD_CYC + 1);
    localparam logic [GUARD_W-1:0] GUARD_LOAD = GUARD_W'(PIN_GUARD_CYC);

    function automatic logic f_toggled(input logic now_v, input logic old_v);
        return now_v != old_v;
    endfunction

    srw_state_t state_reg;
    srw_state_t state_next;
    logic [RST_W-1:0] rst_cnt_reg;
    logic [WDG_W-1:0] wdg_cnt_reg;
    logic rst_act_reg;
    logic [GUARD_W-1:0] guard_reg;
    logic kick_old_reg;
    logic sda_old_reg;
    logic man_level;
    logic ext_force;
    logic src_active;
    logic kick_evt;
    logic wdg_expire;
    logic wr_allowed;

    // pad pull-up keeps an open manual reset pin high
    srw_debounce #(
        .DEB_CYC(DEB_CYC),
        .IDLE_LEVEL(MAN_IDLE_LEVEL)
    ) u_man_deb (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .raw_in(manual_reset_in_n),
        .level_out(man_level)
    );

    // own drive reads back low, so mask it and a short tail after release
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            guard_reg <= GUARD_LOAD;
        end else if (rst_act_reg) begin
            guard_reg <= GUARD_LOAD;
        end else if (guard_reg != '0) begin
            guard_reg <= guard_reg - 1'b1;
        end
    end

    assign ext_force = !rst_n_pin_in && !rst_act_reg && guard_reg == '0;
    assign src_active = supply_low_in || !man_level || ext_force;

    // previous samples for edge detection
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            kick_old_reg <= KICK_IDLE_LEVEL;
            sda_old_reg <= SDA_IDLE_LEVEL;
        end else begin
            kick_old_reg <= watchdog_kick_in;
            sda_old_reg <= sda_in;
        end
    end

    // 40 MHz sampling sees every sda edge of a 400 kHz bus
    assign kick_evt = HAS_KICK_PIN ?
        f_toggled(watchdog_kick_in, kick_old_reg) :
        f_toggled(sda_in, sda_old_reg);

    assign wdg_expire = state_reg == SRW_ST_RUN && wdg_cnt_reg == WDG_LAST;

    // watchdog runs only out of reset and restarts at release
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wdg_cnt_reg <= '0;
        end else if (state_reg != SRW_ST_RUN) begin
            wdg_cnt_reg <= '0;
        end else if (kick_evt || wdg_expire) begin
            wdg_cnt_reg <= '0;
        end else begin
            wdg_cnt_reg <= wdg_cnt_reg + 1'b1;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SRW_ST_HOLD: begin
                if (!src_active) begin
                    state_next = SRW_ST_STRETCH;
                end
            end
            SRW_ST_STRETCH: begin
                if (src_active) begin
                    state_next = SRW_ST_HOLD;
                end else if (rst_cnt_reg == RST_LAST) begin
                    state_next = SRW_ST_RUN;
                end
            end
            SRW_ST_RUN: begin
                if (src_active || wdg_expire) begin
                    state_next = SRW_ST_HOLD;
                end
            end
            default: begin
                state_next = SRW_ST_HOLD;
            end
        endcase
    end

    // power-up starts in hold, so the timeout also follows supply rise
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= SRW_ST_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_cnt_reg <= '0;
        end else if (state_reg != SRW_ST_STRETCH || src_active) begin
            rst_cnt_reg <= '0;
        end else if (rst_cnt_reg != RST_LAST) begin
            rst_cnt_reg <= rst_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_act_reg <= 1'b1;
        end else begin
            rst_act_reg <= state_next != SRW_ST_RUN;
        end
    end

    // both polarities come from one flop so they never disagree
    assign rst_n_pin_out = RST_PIN_DRIVE;
    assign rst_n_pin_oe_out = rst_act_reg;
    assign rst_hi_out = rst_act_reg;

    // pad pull-down reads an open write-protect pin as low
    assign wr_allowed = !write_protect_in && !supply_low_in;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mem_wr_en_out <= 1'b0;
            mem_wr_blocked_out <= 1'b0;
        end else begin
            mem_wr_en_out <= mem_wr_req_in && wr_allowed;
            mem_wr_blocked_out <= mem_wr_req_in && !wr_allowed;
        end
    end

    // page writes wrap inside the 16-byte page, never into the next
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mem_wr_addr_out <= '0;
        end else if (mem_wr_load_in) begin
            mem_wr_addr_out <= mem_wr_addr_in;
        end else if (mem_wr_en_out) begin
            mem_wr_addr_out[PAGE_OFF_W-1:0] <=
                mem_wr_addr_out[PAGE_OFF_W-1:0] + 1'b1;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    sequence s_kick_missed;
        state_reg == SRW_ST_RUN && wdg_cnt_reg == WDG_LAST && !src_active;
    endsequence

    sequence s_stretch_done;
        state_reg == SRW_ST_STRETCH && rst_cnt_reg == RST_LAST
            && !src_active;
    endsequence

    property p_wdg_expire;
        s_kick_missed |=> rst_act_reg && state_reg == SRW_ST_HOLD
            ##1 state_reg == ($past(src_active) ? SRW_ST_HOLD
            : SRW_ST_STRETCH);
    endproperty
    a_wdg_expire: assert property (p_wdg_expire)
        else $error("missed kick did not assert reset");

    property p_kick_restart;
        state_reg == SRW_ST_RUN && kick_evt && !src_active
            |=> wdg_cnt_reg == '0;
    endproperty
    a_kick_restart: assert property (p_kick_restart)
        else $error("kick did not restart watchdog");

    property p_man_reset;
        !man_level |=> rst_act_reg && rst_hi_out && rst_n_pin_oe_out;
    endproperty
    a_man_reset: assert property (p_man_reset)
        else $error("manual reset did not assert reset");

    property p_man_stretch;
        state_reg == SRW_ST_HOLD && !src_active
            |=> state_reg == SRW_ST_STRETCH && rst_cnt_reg == '0
            ##1 rst_act_reg || state_reg != SRW_ST_RUN;
    endproperty
    a_man_stretch: assert property (p_man_stretch)
        else $error("reset not stretched after source cleared");

    property p_ext_force;
        ext_force |=> rst_act_reg [*2];
    endproperty
    a_ext_force: assert property (p_ext_force)
        else $error("forced reset pin did not start reset");

    property p_supply_low;
        supply_low_in |=> rst_act_reg && !mem_wr_en_out;
    endproperty
    a_supply_low: assert property (p_supply_low)
        else $error("supply low did not assert reset");

    property p_release;
        s_stretch_done |=> state_reg == SRW_ST_RUN && !rst_act_reg
            && !rst_hi_out;
    endproperty
    a_release: assert property (p_release)
        else $error("reset not released after timeout");

    property p_early_release;
        state_reg == SRW_ST_STRETCH && rst_cnt_reg != RST_LAST
            |=> rst_act_reg;
    endproperty
    a_early_release: assert property (p_early_release)
        else $error("reset released before timeout");

    property p_polarity;
        rst_hi_out == rst_n_pin_oe_out && rst_n_pin_out == RST_PIN_DRIVE;
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("reset outputs disagree");

    property p_wp_block;
        mem_wr_req_in && write_protect_in
            |=> !mem_wr_en_out && mem_wr_blocked_out;
    endproperty
    a_wp_block: assert property (p_wp_block)
        else $error("write went through while protected");

    property p_wr_pass;
        mem_wr_req_in && !write_protect_in && !supply_low_in
            |=> mem_wr_en_out;
    endproperty
    a_wr_pass: assert property (p_wr_pass)
        else $error("allowed write was dropped");

    property p_page_wrap;
        mem_wr_en_out && !mem_wr_load_in |=>
            mem_wr_addr_out[ADDR_W-1:PAGE_OFF_W] ==
            $past(mem_wr_addr_out[ADDR_W-1:PAGE_OFF_W])
            && mem_wr_addr_out[PAGE_OFF_W-1:0] ==
            $past(mem_wr_addr_out[PAGE_OFF_W-1:0]) + 1'b1;
    endproperty
    a_page_wrap: assert property (p_page_wrap)
        else $error("page write crossed a page boundary");

    property p_wdg_fresh;
        $fell(rst_act_reg) |-> wdg_cnt_reg == '0 ##1 wdg_cnt_reg <= 1;
    endproperty
    a_wdg_fresh: assert property (p_wdg_fresh)
        else $error("watchdog not restarted at release");
endmodule

// File: rtl/srw_pkg.sv
// constants and types for the supervisor, reset stretcher and watchdog
package srw_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    // watchdog window, reset timeout and debounce time, in their own units
    localparam int WDG_TIMEOUT_MS = 1600;
    localparam int RST_TIMEOUT_MS = 200;
    localparam int DEBOUNCE_US = 5000;
    // times convert to cycles by exact multiplication, with no rounding
    localparam int WDG_CYCLES = WDG_TIMEOUT_MS * CYC_PER_MS;
    localparam int RST_CYCLES = RST_TIMEOUT_MS * CYC_PER_MS;
    localparam int DEB_CYCLES = DEBOUNCE_US * CYC_PER_US;
    // serial bus rate and clocks per bus period at that rate
    localparam int SCL_MAX_KHZ = 400;
    localparam int SCL_PERIOD_CYC = CYC_PER_MS / SCL_MAX_KHZ;
    // cycles the own pin drive is masked after release
    localparam int PIN_GUARD_CYC = 2;
    // memory geometry
    localparam int MEM_BITS = 2048;
    localparam int MEM_BYTES = MEM_BITS / 8;
    localparam int PAGE_BYTES = 16;
    localparam int ADDR_W = $clog2(MEM_BYTES);
    localparam int PAGE_OFF_W = $clog2(PAGE_BYTES);
    // reset levels of inputs with pads pulls
    localparam logic MAN_IDLE_LEVEL = 1'b1;
    localparam logic KICK_IDLE_LEVEL = 1'b0;
    localparam logic SDA_IDLE_LEVEL = 1'b1;
    // open-drain reset pin only ever pulls low
    localparam logic RST_PIN_DRIVE = 1'b0;

    typedef enum logic [1:0] {
        SRW_ST_HOLD = 2'h0,
        SRW_ST_STRETCH = 2'h1,
        SRW_ST_RUN = 2'h3
    } srw_state_t;
endpackage

// File: rtl/srw_debounce.sv
// level debouncer: output follows input after it holds steady
`timescale 1ns/1ps
module srw_debounce
    import srw_pkg::*;
#(
    parameter int DEB_CYC = DEB_CYCLES,
    parameter logic IDLE_LEVEL = 1'b1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // level in and filtered level out
    input wire logic raw_in,
    output logic level_out
);
    localparam int CNT_W = $clog2(DEB_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEB_CYC - 1);

    logic [CNT_W-1:0] cnt_reg;
    logic level_reg;

    // counter runs only while input disagrees with the filtered level
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_reg <= '0;
        end else if (raw_in == level_reg || cnt_reg == CNT_LAST) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            level_reg <= IDLE_LEVEL;
        end else if (raw_in != level_reg && cnt_reg == CNT_LAST) begin
            level_reg <= raw_in;
        end
    end

    assign level_out = level_reg;
endmodule

// File: dv/srw_host_model.sv
// host model: kicks the watchdog and can pull the reset pin low
`timescale 1ns/1ps
module srw_host_model #(
    parameter int KICK_GAP = 100
) (
    // clock
    input wire logic clk_in,
    // bench commands
    input wire logic kick_en_in,
    input wire logic pull_en_in,
    // kick line and open-drain pull on the reset pin
    output logic kick_out,
    output logic pin_pull_out
);
    int gap = 0;
    logic en_now = 1'b0;
    logic pull_now = 1'b0;
    logic kick_v = 1'b0;
    logic pull_v = 1'b0;
    assign kick_out = kick_v;
    assign pin_pull_out = pull_v;
    // kicks at half the window, so slow software still keeps the system up
    always @(posedge clk_in) begin
        en_now = kick_en_in;
        pull_now = pull_en_in;
        #1;
        pull_v = pull_now;
        gap = en_now ? gap + 1 : 0;
        if (gap >= KICK_GAP) begin
            gap = 0;
            kick_v = ~kick_v;
        end
    end
endmodule

// File: dv/tb.sv
// testbench for the supervisor with a host model on its far side
`timescale 1ns/1ps
module tb;
    import srw_pkg::*;
    localparam int WDG = 200;
    localparam int RST = 50;
    localparam int DEB = 8;
    typedef struct packed {
        logic wp;
        logic sl;
        logic en;
        logic blk;
    } srw_row_t;
    // protect, supply low, then grant and refuse expected
    srw_row_t rows [4] = '{4'b0010, 4'b1001, 4'b1101, 4'b0101};
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic supply_low = 1'b0;
    logic manual_n = 1'b1;
    logic wp = 1'b0;
    logic load = 1'b0;
    logic req = 1'b0;
    logic kick_en = 1'b0;
    logic pull_en = 1'b0;
    logic [ADDR_W-1:0] addr_in = 8'h1F;
    logic kick, pull, oe, oe2, pin_q, rst_hi, rst_hi2, wr_en, blk;
    logic [ADDR_W-1:0] addr_out;
    wire logic pin_n = !(oe || pull);
    wire logic pin2_n = !(oe2 || pull);
    int n_mismatch = 0;
    int cmp_count = 0;
    int n;

    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    srw_supervisor #(.HAS_KICK_PIN(1'b1), .WDG_CYC(WDG), .RST_CYC(RST),
        .DEB_CYC(DEB)) srw_supervisor_inst (.clk_in(clk_in),
        .nrst_in(nrst_in), .supply_low_in(supply_low),
        .manual_reset_in_n(manual_n), .watchdog_kick_in(kick),
        .sda_in(1'b1), .rst_n_pin_in(pin_n), .rst_n_pin_out(pin_q),
        .rst_n_pin_oe_out(oe), .rst_hi_out(rst_hi),
        .write_protect_in(wp), .mem_wr_load_in(load),
        .mem_wr_addr_in(addr_in), .mem_wr_req_in(req),
        .mem_wr_en_out(wr_en), .mem_wr_addr_out(addr_out),
        .mem_wr_blocked_out(blk));
    // second variant watches the data line instead of the kick pin
    srw_supervisor #(.HAS_KICK_PIN(1'b0), .WDG_CYC(WDG), .RST_CYC(RST),
        .DEB_CYC(DEB)) srw_supervisor_sda_inst (.clk_in(clk_in),
        .nrst_in(nrst_in), .supply_low_in(supply_low),
        .manual_reset_in_n(manual_n), .watchdog_kick_in(1'b0),
        .sda_in(kick), .rst_n_pin_in(pin2_n), .rst_n_pin_out(),
        .rst_n_pin_oe_out(oe2), .rst_hi_out(rst_hi2),
        .write_protect_in(wp), .mem_wr_load_in(load),
        .mem_wr_addr_in(addr_in), .mem_wr_req_in(req),
        .mem_wr_en_out(), .mem_wr_addr_out(), .mem_wr_blocked_out());
    srw_host_model #(.KICK_GAP(100)) srw_host_model_inst (.clk_in(clk_in),
        .kick_en_in(kick_en), .pull_en_in(pull_en), .kick_out(kick),
        .pin_pull_out(pull));

    task automatic tick(input int c);
        repeat (c) @(posedge clk_in);
        #1;
    endtask

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_rng(input string what, input int lo, input int hi);
        cmp_count++;
        if (n < lo || n > hi) begin
            n_mismatch++;
            $display("mismatch %s expected %0d..%0d seen %0d",
                     what, lo, hi, n);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // bounded wait for the reset output to reach a level
    task automatic wait_rst(input logic lvl, input int lim);
        n = 0;
        while (rst_hi !== lvl) begin
            tick(1);
            n++;
            if (n > lim) begin
                n_mismatch++;
                $display("mismatch wait rst_hi expected %b seen %b",
                         lvl, rst_hi);
                complete_run();
            end
        end
    endtask

    always @(negedge clk_in) begin
        if (nrst_in === 1'b1) begin
            check("oe vs rst_hi", rst_hi, oe);
            check("rst pin drive", 8'h00, pin_q);
        end
    end

    initial begin
        #250000;
        n_mismatch++;
        $display("mismatch run time expected end seen hang");
        complete_run();
    end

    initial begin
        tick(3);
        check("rst_hi in reset", 1'b1, rst_hi);
        check("wr_en in reset", 1'b0, wr_en);
        tick(3);
        nrst_in = 1'b1;
        wait_rst(1'b0, RST + 10);
        check_rng("power-up stretch", RST, RST + 2);
        $display("test reset done");
        kick_en = 1'b1;
        foreach (rows[i]) begin
            wp = rows[i].wp;
            supply_low = rows[i].sl;
            req = 1'b1;
            tick(1);
            req = 1'b0;
            check("wr_en", rows[i].en, wr_en);
            check("blocked", rows[i].blk, blk);
        end
        wp = 1'b0;
        tick(1);
        check("rst_hi supply low", 1'b1, rst_hi);
        tick(20);
        check("rst_hi supply held", 1'b1, rst_hi);
        supply_low = 1'b0;
        wait_rst(1'b0, RST + 10);
        check_rng("supply stretch", RST, RST + 2);
        load = 1'b1;
        tick(1);
        load = 1'b0;
        check("addr load", 8'h1F, addr_out);
        req = 1'b1;
        tick(1);
        req = 1'b0;
        check("wr_en page end", 1'b1, wr_en);
        tick(1);
        check("addr wrap", 8'h10, addr_out);
        $display("test write gating done");
        tick(600);
        check("rst_hi kicked", 1'b0, rst_hi);
        check("rst_hi2 kicked", 1'b0, rst_hi2);
        kick_en = 1'b0;
        wait_rst(1'b1, WDG + 10);
        check_rng("watchdog expiry", WDG - 102, WDG + 2);
        check("rst_hi2 expiry", 1'b1, rst_hi2);
        wait_rst(1'b0, RST + 10);
        wait_rst(1'b1, WDG + 10);
        check_rng("watchdog restart", WDG - 2, WDG + 2);
        wait_rst(1'b0, RST + 10);
        kick_en = 1'b1;
        $display("test watchdog done");
        manual_n = 1'b0;
        tick(DEB / 2);
        manual_n = 1'b1;
        tick(DEB + 4);
        check("rst_hi glitch", 1'b0, rst_hi);
        manual_n = 1'b0;
        tick(DEB + 4);
        check("rst_hi manual", 1'b1, rst_hi);
        tick(RST + 20);
        check("rst_hi manual held", 1'b1, rst_hi);
        manual_n = 1'b1;
        wait_rst(1'b0, DEB + RST + 10);
        check_rng("manual stretch", DEB + RST, DEB + RST + 3);
        $display("test manual reset done");
        pull_en = 1'b1;
        tick(4);
        check("rst_hi pin pulled", 1'b1, rst_hi);
        tick(8);
        pull_en = 1'b0;
        tick(2);
        check("rst_hi after pull", 1'b1, rst_hi);
        wait_rst(1'b0, RST + 10);
        $display("test pin reset done");
        complete_run();
    end
endmodule
